// >>> core/input_frame_offset_alignment.sv
// Purpose: per-stream input frame offset alignment for 32 serial streams
// Assumes: input clock, frame pulse, evaluation and stream pins are async
//          and the input clock runs well below a quarter of i_sys_clk
// Notes:   offsets counted in input clock half periods
`timescale 1ns/1ps
`include "frame_offset_params.svh"
module input_frame_offset_alignment
   import frame_offset_pkg::*;
#(
   parameter int STREAMS = 32
) (
   // clock and reset
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_rst,
   // register port
   input  wire logic [`REG_ADDR_W-1:0]   i_addr,
   input  wire logic [`REG_DATA_W-1:0]   i_wr_data,
   input  wire logic                     i_wr,
   input  wire logic                     i_rd,
   output logic      [`REG_DATA_W-1:0]   o_rd_data,
   // serial link pins
   input  wire logic                     i_input_clock,
   input  wire logic                     i_frame_pulse_input_n,
   input  wire logic                     i_frame_eval_n,
   input  wire logic [STREAMS-1:0]       i_rx,
   // aligned receive outputs
   output logic      [STREAMS-1:0]       o_frame_start,
   output logic      [STREAMS-1:0]       o_bit_valid,
   output logic      [STREAMS-1:0]       o_bit_data
);

   localparam int NREGS = STREAMS / `FIELDS_PER_REG;
   localparam int SYNC_W = STREAMS + 3;

   // synchronised pins
   logic [SYNC_W-1:0]  sync_level;
   logic               clk_lvl;
   logic               fp_n_lvl;
   logic               eval_n_lvl;
   logic [STREAMS-1:0] rx_lvl;

   pin_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_pin     ({i_rx, i_frame_eval_n, i_frame_pulse_input_n, i_input_clock}),
      .o_level   (sync_level)
   );

   assign clk_lvl    = sync_level[0];
   assign fp_n_lvl   = sync_level[1];
   assign eval_n_lvl = sync_level[2];
   assign rx_lvl     = sync_level[SYNC_W-1:3];

   // edge detection on filtered levels
   logic clk_lvl_d_r;
   logic eval_n_d_r;
   logic half_edge;
   logic fall_edge;
   logic frame_ref;
   logic eval_fall;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         clk_lvl_d_r <= 1'b0;
         // matches the synchroniser reset level, so no false fall after reset
         eval_n_d_r  <= 1'b0;
      end else begin
         clk_lvl_d_r <= clk_lvl;
         eval_n_d_r  <= eval_n_lvl;
      end
   end

   // every transition is one half period
   assign half_edge = clk_lvl ^ clk_lvl_d_r;
   assign fall_edge = clk_lvl_d_r & ~clk_lvl;
   // frame reference is the low frame pulse seen on a falling edge
   assign frame_ref = fall_edge & ~fp_n_lvl;
   assign eval_fall = eval_n_d_r & ~eval_n_lvl;

   // offset registers
   logic [`REG_DATA_W-1:0] ofs_r [NREGS];
   logic                   wr_hit;
   logic [`REG_ADDR_W-1:0] ofs_idx;

   assign wr_hit  = i_wr && (i_addr <= `REG_OFS_LAST);
   assign ofs_idx = i_addr - `REG_OFS_FIRST;

   genvar r;
   generate
      for (r = 0; r < NREGS; r++) begin : g_reg
         always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
               ofs_r[r] <= `REG_RESET_VAL;
            end else if (wr_hit && (ofs_idx == `REG_ADDR_W'(r))) begin
               ofs_r[r] <= i_wr_data;
            end
         end
      end
   endgenerate

   // delay measurement
   meas_state_t             meas_state_r;
   logic [`MEAS_HCNT_W-1:0] hcnt_r;
   logic [`MEAS_DELAY_W-1:0] meas_delay_r;
   logic                    meas_half_r;
   logic                    meas_done_r;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         meas_state_r <= MEAS_IDLE;
         hcnt_r       <= '0;
         meas_delay_r <= '0;
         meas_half_r  <= 1'b0;
         meas_done_r  <= 1'b0;
      end else begin
         case (meas_state_r)
            MEAS_IDLE: begin
               if (frame_ref) begin
                  meas_state_r <= MEAS_ARMED;
                  hcnt_r       <= '0;
               end
            end
            MEAS_ARMED: begin
               if (eval_fall) begin
                  meas_state_r <= MEAS_DONE_ST;
                  meas_delay_r <= hcnt_r[`MEAS_HCNT_W-1:1];
                  // flag follows input clock phase at the evaluation edge
                  meas_half_r  <= clk_lvl;
                  meas_done_r  <= 1'b1;
               end else if (frame_ref) begin
                  hcnt_r <= '0;
               end else if (half_edge && (hcnt_r != '1)) begin
                  hcnt_r <= hcnt_r + `MEAS_HCNT_W'(1);
               end
            end
            MEAS_DONE_ST: begin
               // result kept until a write to the status register rearms
               if (i_wr && (i_addr == `REG_MEAS_STATUS)) begin
                  meas_state_r <= MEAS_IDLE;
                  meas_done_r  <= 1'b0;
                  meas_delay_r <= '0;
                  meas_half_r  <= 1'b0;
               end
            end
            default: begin
               meas_state_r <= MEAS_IDLE;
            end
         endcase
      end
   end

   // read path, one cycle latency
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_rd_data <= '0;
      end else if (i_rd) begin
         o_rd_data <= '0;
         if (i_addr <= `REG_OFS_LAST) begin
            o_rd_data <= ofs_r[ofs_idx[2:0]];
         end else if (i_addr == `REG_MEAS_STATUS) begin
            o_rd_data[`MEAS_DELAY_HI:`MEAS_DELAY_LO] <= meas_delay_r;
            o_rd_data[`MEAS_HALF_FLAG]              <= meas_half_r;
            o_rd_data[`MEAS_DONE]                   <= meas_done_r;
         end
      end else begin
         o_rd_data <= '0;
      end
   end

   // per-stream aligners
   genvar s;
   generate
      for (s = 0; s < STREAMS; s++) begin : g_stream
         logic [`FIELD_W-1:0] field;
         // stream s sits in register s/4, nibble s%4
         assign field = ofs_r[s / `FIELDS_PER_REG][(s % `FIELDS_PER_REG) * `FIELD_W +: `FIELD_W];

         stream_aligner u_align (
            .i_sys_clk     (i_sys_clk),
            .i_rst         (i_rst),
            .i_half_edge   (half_edge),
            .i_frame_ref   (frame_ref),
            .i_field       (field),
            .i_rx          (rx_lvl[s]),
            .o_frame_start (o_frame_start[s]),
            .o_bit_valid   (o_bit_valid[s]),
            .o_bit_data    (o_bit_data[s])
         );
      end
   endgenerate

endmodule : input_frame_offset_alignment

// >>> core/frame_offset_params.svh
// Purpose: register map, field layout and timing constants of the offset block
// Assumes: 16-bit register data, word indices on a plain register port
// Notes:   definitions only
`ifndef FRAME_OFFSET_PARAMS_SVH
`define FRAME_OFFSET_PARAMS_SVH

// register indices
`define REG_OFS_FIRST      4'h0
`define REG_OFS_LAST       4'h7
`define REG_MEAS_STATUS    4'h8
`define REG_ADDR_W         4

// data widths and reset values
`define REG_DATA_W         16
`define REG_RESET_VAL      16'h0000
`define FIELD_W            4
`define FIELDS_PER_REG     4
`define OFS_BITS_W         3

// field layout inside one 4-bit stream field
`define FLD_HALF_EN        0
`define FLD_OFS_LO         1
`define FLD_OFS_HI         3

// measurement status layout
`define MEAS_DELAY_LO      0
`define MEAS_DELAY_HI      11
`define MEAS_HALF_FLAG     12
`define MEAS_DONE          13
`define MEAS_DELAY_W       12
`define MEAS_HCNT_W        13

`endif

// >>> core/frame_offset_pkg.sv
// Purpose: shared types of the input frame offset block
// Assumes: nothing
// Notes:   constants live in frame_offset_params.svh
package frame_offset_pkg;

   typedef enum logic [1:0] {
      ALIGN_IDLE,
      ALIGN_WAIT,
      ALIGN_RUN
   } align_state_t;

   typedef enum logic [1:0] {
      MEAS_IDLE,
      MEAS_ARMED,
      MEAS_DONE_ST
   } meas_state_t;

endpackage : frame_offset_pkg

// >>> core/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to i_sys_clk
// Notes:   output follows once the second and third stages agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst,
   // pins
   input  wire logic [WIDTH-1:0] i_pin,
   // synchronised level
   output logic      [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // first stage feeds only the second
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= i_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
               o_level[g] <= 1'b0;
            end else if (s2_r[g] == s3_r[g]) begin
               o_level[g] <= s3_r[g];
            end
         end
      end
   endgenerate

endmodule : pin_sync

// >>> core/stream_aligner.sv
// Purpose: per-stream frame start alignment in half input-clock steps
// Assumes: i_half_edge marks every input clock transition, i_frame_ref is
//          one of those edges
// Notes:   target delay in half periods is {offset bits, half enable}
`timescale 1ns/1ps
`include "frame_offset_params.svh"
module stream_aligner
   import frame_offset_pkg::*;
(
   // clock and reset
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst,
   // timing references
   input  wire logic                  i_half_edge,
   input  wire logic                  i_frame_ref,
   // stream configuration and data
   input  wire logic [`FIELD_W-1:0]   i_field,
   input  wire logic                  i_rx,
   // received bits
   output logic                       o_frame_start,
   output logic                       o_bit_valid,
   output logic                       o_bit_data
);

   align_state_t        state_r;
   logic [`FIELD_W-1:0] cnt_r;
   logic                phase_r;
   logic [`FIELD_W-1:0] target;

   // half periods = 2*offset + half enable
   assign target = i_field;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_r       <= ALIGN_IDLE;
         cnt_r         <= '0;
         phase_r       <= 1'b0;
         o_frame_start <= 1'b0;
         o_bit_valid   <= 1'b0;
         o_bit_data    <= 1'b0;
      end else begin
         o_frame_start <= 1'b0;
         o_bit_valid   <= 1'b0;
         if (i_frame_ref) begin
            // zero field takes bit 0 at the frame edge
            if (target == '0) begin
               state_r       <= ALIGN_RUN;
               phase_r       <= 1'b0;
               o_frame_start <= 1'b1;
               o_bit_valid   <= 1'b1;
               o_bit_data    <= i_rx;
            end else begin
               state_r <= ALIGN_WAIT;
               cnt_r   <= `FIELD_W'(1);
            end
         end else if (i_half_edge) begin
            case (state_r)
               ALIGN_WAIT: begin
                  // bit 0 taken once the offset has elapsed
                  if (cnt_r == target) begin
                     state_r       <= ALIGN_RUN;
                     phase_r       <= 1'b0;
                     o_frame_start <= 1'b1;
                     o_bit_valid   <= 1'b1;
                     o_bit_data    <= i_rx;
                  end else begin
                     cnt_r <= cnt_r + `FIELD_W'(1);
                  end
               end
               ALIGN_RUN: begin
                  // sampling phase kept from bit 0
                  phase_r <= ~phase_r;
                  if (phase_r) begin
                     o_bit_valid <= 1'b1;
                     o_bit_data  <= i_rx;
                  end
               end
               ALIGN_IDLE: begin
                  state_r <= ALIGN_IDLE;
               end
               default: begin
                  state_r <= ALIGN_IDLE;
               end
            endcase
         end
      end
   end

endmodule : stream_aligner

// >>> verification/serial_source.sv
// Purpose: far side: input clock, frame pulse, eval pin, streams
// Assumes: clock half period of 6 system cycles, 24 transitions a frame
// Notes:   o_hidx counts transitions since the frame reference fall
`timescale 1ns/1ps
module serial_source (
   // control
   input  wire logic        i_sys_clk,
   input  wire logic        i_run,
   input  wire logic [7:0]  i_eval_at,
   // link pins
   output logic             o_clk_pin = 1'b1,
   output logic             o_fp_n = 1'b1,
   output logic             o_eval_n = 1'b1,
   output logic [31:0]      o_rx = '0,
   // position
   output int               o_hidx = 21
);
   int cnt = 0;
   int seed = 90;
   always @(posedge i_sys_clk) begin
      if (i_run) begin
         cnt <= (cnt == 5) ? 0 : cnt + 1;
         if (cnt == 5) begin
            o_clk_pin <= ~o_clk_pin;
            o_hidx <= (o_hidx == 23) ? 0 : o_hidx + 1;
         end
         o_fp_n <= !(o_hidx == 23 || (o_hidx == 0 && cnt < 3));
         // late in frame so every bit 0 sees one value
         if (o_hidx == 20 && cnt == 3)
            o_rx <= $random(seed);
         o_eval_n <= !(o_hidx == i_eval_at && cnt >= 3);
      end
   end
endmodule : serial_source

// >>> verification/input_frame_offset_alignment_properties.sv
// Purpose: port checker of the offset block
// Assumes: single clock domain
// Notes:   attached by bind below
`timescale 1ns/1ps
`include "frame_offset_params.svh"
module offset_checker #(
   parameter int STREAMS = 32
) (
   input wire logic                   i_sys_clk,
   input wire logic                   i_rst,
   input wire logic [`REG_ADDR_W-1:0] i_addr,
   input wire logic [`REG_DATA_W-1:0] i_wr_data,
   input wire logic                   i_wr,
   input wire logic                   i_rd,
   input wire logic [`REG_DATA_W-1:0] o_rd_data,
   input wire logic [STREAMS-1:0]     o_frame_start,
   input wire logic [STREAMS-1:0]     o_bit_valid,
   input wire logic [STREAMS-1:0]     o_bit_data
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   a_rd_idle_zero: assert property (!$past(i_rd) |-> o_rd_data == '0)
      else $error("read data outside read cycle");
   a_wr_rd_back: assert property ((i_wr && i_addr <= `REG_OFS_LAST) ##1
      (i_rd && i_addr == $past(i_addr)) |=> o_rd_data == $past(i_wr_data, 2))
      else $error("register read back differs");
   a_unmapped_zero: assert property (i_rd && i_addr > `REG_MEAS_STATUS |=> o_rd_data == '0)
      else $error("unmapped read not zero");
   a_reset_clear: assert property ($past(i_rst) && i_rd |=> o_rd_data == '0)
      else $error("register not clear after reset");
   a_quiet_rst: assert property ($past(i_rst) |-> (o_frame_start | o_bit_valid) == '0)
      else $error("stream output right after reset");
   a_start_valid: assert property ((o_frame_start & ~o_bit_valid) == '0)
      else $error("frame start without bit");
   a_start_single: assert property (o_frame_start != '0 |=>
      (o_frame_start & $past(o_frame_start)) == '0)
      else $error("frame start longer than a cycle");
   a_data_hold: assert property (!$past(i_rst) |->
      ((o_bit_data ^ $past(o_bit_data)) & ~o_bit_valid) == '0)
      else $error("bit data moved without valid");
endmodule : offset_checker
bind input_frame_offset_alignment offset_checker #(.STREAMS(STREAMS)) u_chk (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
   .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_frame_start(o_frame_start),
   .o_bit_valid(o_bit_valid), .o_bit_data(o_bit_data));

// >>> verification/testbench.sv
// Purpose: self-checking bench of the offset block
// Assumes: serial_source drives the link pins
// Notes:   integer register model, start timing from transition index
`timescale 1ns/1ps
module testbench;
   logic        clk = 0;
   logic        rst = 1;
   logic [3:0]  addr = '0;
   logic [15:0] wdat = '0;
   logic        wr = 0;
   logic        rd = 0;
   logic [7:0]  eval_at = 8'hff;
   logic [15:0] rdat, q;
   logic [31:0] rx, fs, bv, bd;
   logic        cpin, fpn, evn;
   int          hidx, h1, h2, h3, f, cyc = 0, seed = 90;
   int          error_cnt = 0, samples_checked = 0;
   int          regs[8] = '{default: 0}, starts[32];
   bit          run = 0, chk_on = 0;
   always #5 clk = ~clk;
   input_frame_offset_alignment #(.STREAMS(32)) dut (
      .i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wdat), .i_wr(wr),
      .i_rd(rd), .o_rd_data(rdat), .i_input_clock(cpin), .i_frame_pulse_input_n(fpn),
      .i_frame_eval_n(evn), .i_rx(rx), .o_frame_start(fs), .o_bit_valid(bv),
      .o_bit_data(bd));
   serial_source src (.i_sys_clk(clk), .i_run(run), .i_eval_at(eval_at),
      .o_clk_pin(cpin), .o_fp_n(fpn), .o_eval_n(evn), .o_rx(rx), .o_hidx(hidx));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   task automatic chk(input bit ok, input string m);
      samples_checked++;
      if (!ok) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdat <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
      if (a < 8) regs[a[2:0]] = d;
      @(posedge clk);
   endtask : wr_reg
   // write then read back with no gap between the strobes
   task automatic wr_rd(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdat <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
      rd <= 1;
      regs[a[2:0]] = d;
      @(posedge clk);
      rd <= 0;
      @(posedge clk);
      q = rdat;
      chk(q === d, "read back after write");
   endtask : wr_rd
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      @(posedge clk);
      q = rdat;
      chk(q === e, "read data");
   endtask : rd_chk
   // waits for the lagged transition index to arrive at v
   task automatic wait_h(input int v);
      int p;
      do begin
         p = h3;
         @(posedge clk);
      end while (h3 != v || p == v);
   endtask : wait_h
   task automatic run_cfg();
      starts = '{default: 0};
      wait_h(12);
      wait_h(1);
      chk_on <= 1;
      wait_h(1);
      wait_h(1);
      chk_on <= 0;
      @(posedge clk);
      foreach (starts[k]) chk(starts[k] == 2, "frame start count");
   endtask : run_cfg
   // h3 lags the index so a 3..8 cycle pin latency lands in one slot
   // ceiling well above the few thousand cycles the tests take
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("unexpected at %0t: timeout", $time);
         give_verdict();
      end
   end
   always @(posedge clk) begin
      h1 <= hidx;
      h2 <= h1;
      h3 <= h2;
      if (chk_on)
         for (int k = 0; k < 32; k++) begin
            f = (regs[k / 4] >> (4 * (k % 4))) & 15;
            if (fs[k] === 1'b1) begin
               starts[k]++;
               chk(h3 == f && bd[k] === rx[k], "frame start place");
            end
            if (bv[k] === 1'b1)
               chk(h3 >= f && (h3 - f) % 2 == 0, "bit place");
         end
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 0;
      for (int a = 0; a < 16; a++) rd_chk(4'(a), 16'h0000);
      $display("test reset values done");
      for (int a = 0; a < 16; a++)
         if (a != 8) wr_reg(4'(a), 16'($random(seed)));
      for (int a = 0; a < 16; a++)
         rd_chk(4'(a), a < 8 ? 16'(regs[a % 8]) : 16'h0000);
      for (int a = 0; a < 8; a++)
         wr_rd(4'(a), 16'($random(seed)));
      $display("test register map done");
      run <= 1;
      for (int r = 0; r < 3; r++) begin
         for (int a = 0; a < 8; a++)
            wr_reg(4'(a), r == 0 ? 16'h3210 + 16'(a % 4) * 16'h4444 : 16'($random(seed)));
         run_cfg();
      end
      $display("test alignment done");
      for (int e = 7; e < 9; e++) begin
         eval_at <= 8'(e);
         wr_reg(4'h8, 16'h0000);
         wait_h(12);
         wait_h(12);
         // whole periods are the transition count at the evaluation edge halved
         rd_chk(4'h8, {2'b00, 1'b1, e % 2 == 1, 12'(e / 2)});
         chk(q[13:12] === {1'b1, e % 2 == 1}, "measured flag");
         wr_reg(4'h0, {regs[0][15:4], q[2:0], ~q[12]});
         run_cfg();
      end
      $display("test measurement done");
      give_verdict();
   end
endmodule : testbench
